// ==== smx_bus_cycle.sv ====
`timescale 1ns/1ns
`include "smx_cfg.svh"
// four-phase processor bus cycle generator with strobes
module smx_bus_cycle (
   // clock, reset and cpu enable
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic cpu_en,
   // request
   input wire smx_pkg::smx_mem_req_t req,
   output logic busy,
   // memory side
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic wr_strobe_n,
   output logic rd_strobe_n
);
   import smx_pkg::*;
   logic [1:0] ph_r, ph_nxt;
   logic act_r, act_nxt;
   logic isrd_r, isrd_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic [7:0] wd_r, wd_nxt;
   logic wrn_r, wrn_nxt, rdn_r, rdn_nxt;

   always_comb begin
      ph_nxt = ph_r;
      act_nxt = act_r;
      isrd_nxt = isrd_r;
      addr_nxt = addr_r;
      wd_nxt = wd_r;
      wrn_nxt = 1'b1;
      rdn_nxt = 1'b1;
      if (cpu_en) begin
         if (!act_r) begin
            if (req.rd || req.wr) begin
               act_nxt = 1'b1;
               ph_nxt = 2'h0;
               isrd_nxt = req.rd;
               addr_nxt = req.addr;
               wd_nxt = req.wdata;
            end
         end else begin
            // strobe held in the middle two phases of four; see [R08]
            ph_nxt = ph_r + 2'h1;
            if (ph_r == 2'(`SMX_BUS_CYC_CLKS - 1)) begin
               act_nxt = 1'b0;
            end
         end
      end
      if (act_nxt && (ph_nxt == 2'h1 || ph_nxt == 2'h2)) begin
         rdn_nxt = !isrd_nxt;
         wrn_nxt = isrd_nxt;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ph_r <= 2'h0;
         act_r <= 1'b0;
         isrd_r <= 1'b0;
         addr_r <= 16'h0000;
         wd_r <= 8'h00;
         wrn_r <= 1'b1;
         rdn_r <= 1'b1;
      end else begin
         ph_r <= ph_nxt;
         act_r <= act_nxt;
         isrd_r <= isrd_nxt;
         addr_r <= addr_nxt;
         wd_r <= wd_nxt;
         wrn_r <= wrn_nxt;
         rdn_r <= rdn_nxt;
      end
   end

   assign busy = act_r;
   assign mem_addr = addr_r;   // separate address bus; see [R09]
   assign mem_wdata = wd_r;
   assign wr_strobe_n = wrn_r;
   assign rd_strobe_n = rdn_r;
endmodule

// ==== smx_cfg.svh ====
`ifndef SMX_CFG_SVH
`define SMX_CFG_SVH
// port c function bit positions
`define SMX_PCCFG_WR_BIT 6
`define SMX_PCCFG_RD_BIT 7
// cycle phases per processor bus cycle
`define SMX_BUS_CYC_CLKS 4
// clock output divide ratios (half periods in mclk)
`define SMX_CLKO_FAST_DIV 1
`define SMX_CLKO_SLOW_DIV 2
// oscillator restart settle time
`define SMX_OSC_SETTLE_NS 1000
`define SMX_CLK_PERIOD_NS 100
`define SMX_OSC_SETTLE_CYC ((`SMX_OSC_SETTLE_NS + `SMX_CLK_PERIOD_NS - 1) / `SMX_CLK_PERIOD_NS)
`endif

// ==== smx_ext_mem.sv ====
`timescale 1ns/1ns
// external memory on the processor bus: logs strobe phases and writes
module smx_ext_mem (
   // clock and log clear
   input wire logic mclk,
   input wire logic clr,
   // memory bus
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_n,
   input wire logic rd_n,
   // observation
   output logic [7:0] rd_cnt,
   output logic [7:0] wr_cnt,
   output logic [15:0] wr_addr,
   output logic [7:0] wr_data
);
   always @(posedge mclk) begin
      if (clr) begin
         rd_cnt <= 8'h00;
         wr_cnt <= 8'h00;
      end else begin
         if (rd_n === 1'b0) begin
            rd_cnt <= rd_cnt + 8'h01;
         end
         // address taken whole, apart from data
         if (wr_n === 1'b0) begin
            wr_cnt <= wr_cnt + 8'h01;
            wr_addr <= addr;
            wr_data <= wdata;
         end
      end
   end
endmodule

// ==== smx_pkg.sv ====
package smx_pkg;
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
   } smx_port_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic rd;
      logic wr;
   } smx_mem_req_t;
   typedef enum logic [2:0] {
      SMX_RUN = 3'b001,
      SMX_SUSP = 3'b010,
      SMX_WAKE = 3'b100
   } smx_pwr_t;
endpackage

// ==== smx_top.sv ====
`timescale 1ns/1ns
`include "smx_cfg.svh"
// Functional notes
// [R01] port c bit six is general io when the write select bit is 0, else the write strobe.
// [R02] port c bit seven is general io when the read select bit is 0, else the read strobe.
// [R03] the clock output runs at twice the slow rate, or at the slow rate in slow cpu mode.
// [R04] the clock output pin is not driven while the clock output enable bit is 0.
// [R05] a falling wake edge during suspend restarts the oscillator and interrupts the cpu.
// [R06] while wake is held low the device does not enter suspend.
// [R07] the speed strap selects slow cpu speed when high and fast when low.
// [R08] each processor bus cycle lasts four clock periods.
// [R09] external memory uses a sixteen bit address bus apart from the data bus.
// [R10] a pin in strobe mode ignores its port latch and output enable.
module smx_top #(
   parameter int SETTLE_CYC = `SMX_OSC_SETTLE_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // configuration
   input wire logic [7:0] port_c_function_config,
   input wire logic clock_output_enable,
   input wire logic cpu_speed_strap,
   // port c general io
   input wire smx_pkg::smx_port_t port_c_gpio,
   input wire logic [7:0] port_c_pin_in,
   output smx_pkg::smx_port_t port_c_pin,
   output logic [7:0] port_c_state,
   // processor memory request
   input wire smx_pkg::smx_mem_req_t mem_req,
   output logic mem_busy,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata,
   // clock output pin
   output logic clock_output_pin,
   output logic clock_output_oe_n,
   // power control
   input wire logic wake_n,
   input wire logic suspend_req,
   output logic osc_run,
   output logic wake_irq,
   output logic cpu_slow
);
   import smx_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [7:0] pin_s1_r, pin_s2_r;
   logic strap_s1_r, strap_s2_r, wake_s1_r, wake_s2_r, wake_d_r;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1_r <= 8'h00;
         pin_s2_r <= 8'h00;
         strap_s1_r <= 1'b0;
         strap_s2_r <= 1'b0;
         wake_s1_r <= 1'b1;
         wake_s2_r <= 1'b1;
         wake_d_r <= 1'b1;
      end else begin
         pin_s1_r <= port_c_pin_in;
         pin_s2_r <= pin_s1_r;
         strap_s1_r <= cpu_speed_strap;
         strap_s2_r <= strap_s1_r;
         wake_s1_r <= wake_n;
         wake_s2_r <= wake_s1_r;
         wake_d_r <= wake_s2_r;
      end
   end
   assign port_c_state = pin_s2_r;

   ////////////////////////////////////////////////////////////////////////////
   // speed strap, caught once after reset release
   logic slow_r, slow_nxt, strap_done_r, strap_done_nxt;
   logic [1:0] strap_wait_r, strap_wait_nxt;
   always_comb begin
      slow_nxt = slow_r;
      strap_done_nxt = strap_done_r;
      strap_wait_nxt = strap_wait_r;
      if (strap_wait_r != 2'h3) begin
         strap_wait_nxt = strap_wait_r + 2'h1;
      end else if (!strap_done_r) begin
         slow_nxt = strap_s2_r;   // high means slow; see [R07]
         strap_done_nxt = 1'b1;
      end
   end
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         slow_r <= 1'b0;
         strap_done_r <= 1'b0;
         strap_wait_r <= 2'h0;
      end else begin
         slow_r <= slow_nxt;
         strap_done_r <= strap_done_nxt;
         strap_wait_r <= strap_wait_nxt;
      end
   end
   assign cpu_slow = slow_r;

   ////////////////////////////////////////////////////////////////////////////
   // power state
   smx_pwr_t pwr_r, pwr_nxt;
   logic [15:0] settle_r, settle_nxt;
   logic irq_nxt, irq_r;
   logic wake_fall;
   assign wake_fall = wake_d_r && !wake_s2_r;
   always_comb begin
      pwr_nxt = pwr_r;
      settle_nxt = settle_r;
      irq_nxt = 1'b0;
      unique case (pwr_r)
         SMX_RUN: begin
            if (suspend_req && wake_s2_r) begin   // see [R06]
               pwr_nxt = SMX_SUSP;
            end
         end
         SMX_SUSP: begin
            if (wake_fall) begin   // see [R05]
               pwr_nxt = SMX_WAKE;
               settle_nxt = 16'(SETTLE_CYC);
            end
         end
         SMX_WAKE: begin
            if (settle_r <= 16'h0001) begin
               pwr_nxt = SMX_RUN;
               irq_nxt = 1'b1;   // see [R05]
            end else begin
               settle_nxt = settle_r - 16'h0001;
            end
         end
      endcase
   end
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pwr_r <= SMX_RUN;
         settle_r <= 16'h0000;
         irq_r <= 1'b0;
      end else begin
         pwr_r <= pwr_nxt;
         settle_r <= settle_nxt;
         irq_r <= irq_nxt;
      end
   end
   assign osc_run = (pwr_r != SMX_SUSP);
   assign wake_irq = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // clock output divider and cpu enable
   logic [1:0] div_r, div_nxt;
   logic clko_r, clko_nxt;
   logic cpu_en;
   always_comb begin
      clko_nxt = clko_r;
      div_nxt = div_r + 2'h1;
      // half period of one or two mclk; see [R03]
      if (div_nxt >= (slow_r ? 2'(`SMX_CLKO_SLOW_DIV) : 2'(`SMX_CLKO_FAST_DIV))) begin
         div_nxt = 2'h0;
         clko_nxt = !clko_r;
      end
      if (!osc_run) begin
         div_nxt = 2'h0;
         clko_nxt = 1'b0;
      end
   end
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         div_r <= 2'h0;
         clko_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         clko_r <= clko_nxt;
      end
   end
   assign cpu_en = osc_run && (!slow_r || div_r == 2'h0);
   assign clock_output_pin = clko_r;
   assign clock_output_oe_n = !clock_output_enable;   // see [R04]

   ////////////////////////////////////////////////////////////////////////////
   // memory bus cycle
   logic wr_n, rd_n;
   smx_bus_cycle u_bus (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .cpu_en(cpu_en),
      .req(mem_req),
      .busy(mem_busy),
      .mem_addr(mem_addr),
      .mem_wdata(mem_wdata),
      .wr_strobe_n(wr_n),
      .rd_strobe_n(rd_n)
   );

   ////////////////////////////////////////////////////////////////////////////
   // port c pin mux
   always_comb begin
      port_c_pin = port_c_gpio;
      if (port_c_function_config[`SMX_PCCFG_WR_BIT]) begin   // see [R01]
         port_c_pin.out[`SMX_PCCFG_WR_BIT] = wr_n;   // see [R10]
         port_c_pin.oe_n[`SMX_PCCFG_WR_BIT] = 1'b0;
      end
      if (port_c_function_config[`SMX_PCCFG_RD_BIT]) begin   // see [R02]
         port_c_pin.out[`SMX_PCCFG_RD_BIT] = rd_n;   // see [R10]
         port_c_pin.oe_n[`SMX_PCCFG_RD_BIT] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_no_susp_wake_low;
      @(posedge mclk) disable iff (sys_rst)
      (pwr_r == SMX_RUN && !wake_s2_r) |=> pwr_r != SMX_SUSP;
   endproperty
   a_no_susp_wake_low: assert property (p_no_susp_wake_low) else $error("suspend with wake low"); // see [R06]
   property p_wake_restart;
      @(posedge mclk) disable iff (sys_rst)
      (pwr_r == SMX_SUSP && wake_fall) |=> osc_run;
   endproperty
   a_wake_restart: assert property (p_wake_restart) else $error("wake did not restart"); // see [R05]
   property p_irq_run;
      @(posedge mclk) disable iff (sys_rst)
      wake_irq |-> pwr_r == SMX_RUN && $past(pwr_r) == SMX_WAKE;
   endproperty
   a_irq_run: assert property (p_irq_run) else $error("irq without wake"); // see [R05]
   property p_clko_oe;
      @(posedge mclk) disable iff (sys_rst)
      !clock_output_enable |-> clock_output_oe_n;
   endproperty
   a_clko_oe: assert property (p_clko_oe) else $error("clock pin driven while off"); // see [R04]
   property p_clko_fast;
      @(posedge mclk) disable iff (sys_rst)
      (osc_run && !slow_r && $past(osc_run) && strap_done_r) |-> clko_r != $past(clko_r);
   endproperty
   a_clko_fast: assert property (p_clko_fast) else $error("fast clock not toggling"); // see [R03]
   property p_wr_mux;
      @(posedge mclk) disable iff (sys_rst)
      port_c_function_config[6] |-> port_c_pin.out[6] == wr_n && !port_c_pin.oe_n[6];
   endproperty
   a_wr_mux: assert property (p_wr_mux) else $error("write strobe not on pin"); // see [R01]
   property p_rd_mux;
      @(posedge mclk) disable iff (sys_rst)
      !port_c_function_config[7] |-> port_c_pin.out[7] == port_c_gpio.out[7];
   endproperty
   a_rd_mux: assert property (p_rd_mux) else $error("gpio not on pin seven"); // see [R02]
   property p_cycle_len;
      @(posedge mclk) disable iff (sys_rst)
      ($rose(mem_busy) && !slow_r && osc_run) |-> mem_busy [*4] ##1 !mem_busy;
   endproperty
   a_cycle_len: assert property (p_cycle_len) else $error("bus cycle not four"); // see [R08]
   property p_strap;
      @(posedge mclk) disable iff (sys_rst)
      $rose(strap_done_r) |-> slow_r == strap_s2_r;
   endproperty
   a_strap: assert property (p_strap) else $error("strap not captured"); // see [R07]
endmodule

// ==== strobe_mux_clock_wake_ctrl_tb.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
   $display("[FAIL] %0t value mismatch", $time); end end
module strobe_mux_clock_wake_ctrl_tb;
   import smx_pkg::*;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic clr = 1'b1;
   logic [7:0] port_c_function_config = 8'h00;
   logic clock_output_enable = 1'b0;
   logic cpu_speed_strap = 1'b0;
   logic wake_n = 1'b1;
   logic suspend_req = 1'b0;
   smx_port_t port_c_gpio = '0;
   smx_mem_req_t mem_req = '0;
   smx_port_t port_c_pin;
   logic [7:0] pin_lvl, port_c_state, mem_wdata, rd_cnt, wr_cnt, wr_data;
   logic [15:0] mem_addr, wr_addr;
   logic mem_busy, clock_output_pin, clock_output_oe_n, osc_run, wake_irq, cpu_slow;
   int errors = 0;
   int checks = 0;
   // pins pulled high when released
   assign pin_lvl = (port_c_pin.out & ~port_c_pin.oe_n) | port_c_pin.oe_n;
   smx_top #(.SETTLE_CYC(2)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
      .port_c_function_config(port_c_function_config),
      .clock_output_enable(clock_output_enable), .cpu_speed_strap(cpu_speed_strap),
      .port_c_gpio(port_c_gpio), .port_c_pin_in(pin_lvl), .port_c_pin(port_c_pin),
      .port_c_state(port_c_state), .mem_req(mem_req), .mem_busy(mem_busy),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .clock_output_pin(clock_output_pin),
      .clock_output_oe_n(clock_output_oe_n), .wake_n(wake_n), .suspend_req(suspend_req),
      .osc_run(osc_run), .wake_irq(wake_irq), .cpu_slow(cpu_slow));
   smx_ext_mem mem_u (.mclk(mclk), .clr(clr), .addr(mem_addr), .wdata(mem_wdata),
      .wr_n(pin_lvl[6]), .rd_n(pin_lvl[7]), .rd_cnt(rd_cnt), .wr_cnt(wr_cnt),
      .wr_addr(wr_addr), .wr_data(wr_data));
   initial begin
      forever #50 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic wait_sig(input int sel, input logic v);
      int n;
      n = 0;
      while ((sel == 0 ? mem_busy : wake_irq) !== v) begin
         tick(1);
         n++;
         if (n > 40) begin
            errors++;
            give_verdict();
         end
      end
   endtask
   task automatic do_reset(input logic strap);
      sys_rst = 1'b1;
      cpu_speed_strap = strap;
      tick(16);
      `CHK({osc_run, wake_irq, mem_busy, clock_output_pin}, 4'h8)
      sys_rst = 1'b0;
      tick(6);
      `CHK(cpu_slow, strap)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_mux();
      port_c_function_config = 8'h00;
      port_c_gpio = '{out: 8'h5a, oe_n: 8'h0f};
      tick(5);
      `CHK(port_c_pin, port_c_gpio)
      `CHK(port_c_state, 8'h5f)
      port_c_function_config = 8'hc0;
      tick(1);
      `CHK({port_c_pin.out[7:6], port_c_pin.oe_n[7:6]}, 4'hc)
      port_c_gpio = '{out: 8'h00, oe_n: 8'hff};
      tick(1);
      `CHK({port_c_pin.out[7:6], port_c_pin.oe_n[7:6]}, 4'hc)
      `CHK(port_c_pin.out[5:0], 6'h00)
   endtask
   task automatic t_clock(input int m);
      int n;
      logic last;
      n = 0;
      clock_output_enable = 1'b1;
      tick(4);
      `CHK(clock_output_oe_n, 1'b0)
      last = clock_output_pin;
      repeat (8) begin
         tick(1);
         n += int'(clock_output_pin !== last);
         last = clock_output_pin;
      end
      `CHK(n, 8 / m)
      clock_output_enable = 1'b0;
      tick(1);
      `CHK(clock_output_oe_n, 1'b1)
   endtask
   task automatic bus_op(input logic rd, input logic wr, input logic [15:0] a,
                         input logic [7:0] d, input int m);
      int n;
      n = 0;
      tick(1);
      clr = 1'b0;
      mem_req = '{addr: a, wdata: d, rd: rd, wr: wr};
      wait_sig(0, 1'b1);
      mem_req = '0;
      `CHK(mem_addr, a)
      while (mem_busy === 1'b1 && n < 40) begin
         n++;
         tick(1);
      end
      `CHK(n, 4 * m)
      if (n >= 40) begin
         give_verdict();
      end
      tick(1);
      `CHK(rd_cnt, 8'(rd ? 2 * m : 0))
      `CHK(wr_cnt, 8'((wr && !rd) ? 2 * m : 0))
      if (wr && !rd) begin
         `CHK({wr_addr, wr_data}, {a, d})
      end
      clr = 1'b1;
   endtask
   task automatic t_wake();
      // wake held low and synchronised before suspend is asked for
      wake_n = 1'b0;
      tick(3);
      suspend_req = 1'b1;
      tick(5);
      `CHK(osc_run, 1'b1)
      `CHK(wake_irq, 1'b0)
      wake_n = 1'b1;
      tick(3);
      `CHK(osc_run, 1'b0)
      suspend_req = 1'b0;
      wake_n = 1'b0;
      wait_sig(1, 1'b1);
      `CHK(osc_run, 1'b1)
      tick(1);
      `CHK(wake_irq, 1'b0)
      wake_n = 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset(1'b0);
      t_mux();
      t_clock(1);
      bus_op(1'b0, 1'b1, 16'ha5c3, 8'h3c, 1);
      bus_op(1'b1, 1'b0, 16'hffff, 8'h00, 1);
      bus_op(1'b1, 1'b1, 16'h0001, 8'h81, 1);
      t_wake();
      do_reset(1'b1);
      t_clock(2);
      bus_op(1'b0, 1'b1, 16'h5a00, 8'he7, 2);
      give_verdict();
   end
endmodule
